// ---- design/pwc_defs.svh ----
// Purpose: constants of the input function and alarm relay block
// Assumes: 125 MHz system clock, 32-bit Avalon-MM register port
// Notes: definitions only
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PWC_OFS_CFG      5'h00
`define PWC_OFS_AIN1_RNG 5'h04
`define PWC_OFS_AIN2_RNG 5'h08
`define PWC_OFS_RETX_RNG 5'h0C
`define PWC_OFS_STATUS   5'h10
`define PWC_OFS_IRQ_STAT 5'h14
`define PWC_OFS_IRQ_MASK 5'h18
`define PWC_OFS_SP_LOCAL 5'h1C

// ****************************************
// config field positions (lsb)
// ****************************************
`define PWC_CFG_DIN1_FN 0
`define PWC_CFG_DIN2_FN 4
`define PWC_CFG_FB      8
`define PWC_CFG_FIRE    12
`define PWC_CFG_LOG     16
`define PWC_CFG_BAKE    17
`define PWC_CFG_AIN2_FN 20
`define PWC_CFG_ALM_FN  24
`define PWC_CFG_RETX    28
// range registers: low bound [11:0], high bound [27:16]
`define PWC_RNG_HI      16

// ****************************************
// reset values
// ****************************************
`define PWC_RST_CFG   32'h0000_0000
`define PWC_RST_RNG   32'h0FFF_0000
`define PWC_RST_MASK  4'h0
`define PWC_RST_SP    10'h000

// ****************************************
// scaling and timing
// ****************************************
`define PWC_PCT_FULL  1000
`define PWC_CLK_NS    8
`define PWC_FILT_NS   1000000
`define PWC_FILT_CYC  ((`PWC_FILT_NS + `PWC_CLK_NS - 1) / `PWC_CLK_NS)

`endif

// ---- design/pwc_pkg.sv ----
// Purpose: types shared by the input function and alarm relay block
// Assumes: nothing beyond the constants header
// Notes: enum order is the register encoding
package pwc_pkg;
	// digital input function, three bits in config
	typedef enum logic [2:0] {DF_NONE, DF_ENABLE, DF_VOLT_FB, DF_LOC_REM,
		DF_PHASE, DF_AIN_SEL, DF_LOGGING, DF_BAKEOUT} pwc_din_fn_t;
	// feedback selection
	typedef enum logic [2:0] {FB_VOLT, FB_VOLT_SQ, FB_POWER, FB_CUR_SQ,
		FB_CUR, FB_EXTERNAL, FB_NONE} pwc_fb_t;
	// firing method
	typedef enum logic [2:0] {FI_ZERO_CROSS, FI_SINGLE, FI_BURST,
		FI_BURST_RAMP, FI_PHASE} pwc_fire_t;
	// use of the second analog input
	typedef enum logic [1:0] {A2_ALT_SP, A2_EXT_FB, A2_CUR_LIM} pwc_ain2_fn_t;
	// retransmitted quantity
	typedef enum logic [1:0] {RT_SETPOINT, RT_CURRENT, RT_VOLTAGE, RT_POWER} pwc_retx_t;
	// alarm sources from the measurement logic
	typedef struct packed {
		logic heater_break;
		logic shorted_sw;
		logic cur_limit;
		logic comm_wdog;
		logic heatsink_ot;
	} pwc_alarm_t;
	// resolved control to the loop and firing logic
	typedef struct packed {
		logic out_enable;
		pwc_fb_t feedback;
		pwc_fire_t firing;
		logic sp_remote;
		logic remote_source_select;
		logic logging_en;
		logic bakeout_en;
	} pwc_ctrl_t;
endpackage : pwc_pkg

// ---- design/pwc_din_filt.sv ----
// Purpose: synchronise and debounce one isolated digital input
// Assumes: pin is asynchronous to mclk_i
// Notes: output changes only after the level held FILT_CYC cycles
`timescale 1ns/10ps
`default_nettype none
module pwc_din_filt #(
	parameter int FILT_CYC = 125000
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic change_o
);
	localparam int CW = $clog2(FILT_CYC + 1);
	logic meta_q; // first stage, read only by sync_q
	logic sync_q; // second stage
	logic [CW-1:0] cnt_q; // cycles the new level has stood

	// ****************************************
	// two-stage synchroniser
	// ****************************************
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end

	// ****************************************
	// stability filter
	// ****************************************
	// glitches shorter than the window restart the count
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
			level_o <= 1'b0;
			change_o <= 1'b0;
		end else begin
			change_o <= 1'b0;
			if (sync_q == level_o) begin
				cnt_q <= '0;
			end else if (cnt_q == CW'(FILT_CYC - 1)) begin
				cnt_q <= '0;
				level_o <= sync_q;
				change_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule : pwc_din_filt
`default_nettype wire

// ---- design/pwc_scale.sv ----
// Purpose: map a raw analog reading to tenths of a percent of range
// Assumes: lo below hi for a meaningful range
// Notes: clamps outside the range; one cycle latency
`timescale 1ns/10ps
`default_nettype none
`include "pwc_defs.svh"
module pwc_scale #(
	parameter int RW = 12
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [RW-1:0] raw_i,
	input wire logic [RW-1:0] lo_i,
	input wire logic [RW-1:0] hi_i,
	output logic [9:0] pct_o
);
	logic [RW+9:0] num; // offset times full scale
	logic [RW+9:0] quo; // quotient before narrowing

	// ****************************************
	// percent of span
	// ****************************************
	// divider is combinational; inputs change slowly so timing is relaxed
	always_comb begin
		num = (RW+10)'(raw_i - lo_i) * (RW+10)'(`PWC_PCT_FULL);
		quo = (hi_i > lo_i) ? num / (RW+10)'(hi_i - lo_i) : '0;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pct_o <= '0;
		end else if (raw_i <= lo_i) begin
			pct_o <= '0;
		end else if (raw_i >= hi_i) begin
			pct_o <= 10'(`PWC_PCT_FULL);
		end else begin
			pct_o <= quo[9:0];
		end
	end
endmodule : pwc_scale
`default_nettype wire

// ---- design/pwc_io_ctrl.sv ----
// Purpose: digital input functions, analog scaling, alarm relay, retransmit
// Assumes: alarm and measurement inputs come from logic on mclk_i
// Notes: registers over Avalon-MM, one wait state per access
`timescale 1ns/10ps
`default_nettype none
`include "pwc_defs.svh"
module pwc_io_ctrl #(
	parameter int FILT_CYC = `PWC_FILT_CYC,
	parameter int RW = 12
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// pins and panel
	input wire logic [1:0] din_i,
	input wire logic aux_pwr_i,
	input wire logic panel_lr_press_i,
	// analog readings and measured quantities
	input wire logic [RW-1:0] ain1_raw_i,
	input wire logic [RW-1:0] ain2_raw_i,
	input wire logic [9:0] cur_pct_i,
	input wire logic [9:0] volt_pct_i,
	input wire logic [9:0] pwr_pct_i,
	input wire pwc_pkg::pwc_alarm_t alarm_i,
	// resolved controls
	output pwc_pkg::pwc_ctrl_t ctrl_o,
	output logic [9:0] setpoint_o,
	output logic [9:0] ext_fb_o,
	output logic [9:0] cur_lim_sp_o,
	output logic hb_mon_en_o,
	output logic short_mon_en_o,
	output logic relay_energize_o,
	output logic [RW-1:0] retx_o,
	output logic irq_o
);
	// ****************************************
	// declarations
	// ****************************************
	logic [31:0] cfg_q; // function and mode selection
	logic [31:0] ain1_rng_q; // first analog range
	logic [31:0] ain2_rng_q; // second analog range
	logic [31:0] retx_rng_q; // retransmit output span
	logic [9:0] sp_local_q; // keypad or comms set point
	logic [3:0] irq_stat_q; // sticky events
	logic [3:0] irq_mask_q; // event enables
	logic ack_q; // second cycle of an access
	logic [31:0] rdata_q; // read data held for the answer
	logic panel_remote_q; // panel toggle state
	logic aux_meta_q; // first stage, feeds aux_q only
	logic aux_q; // synchronised aux power
	logic alarm_d; // heat sink or any selected alarm
	logic alarm_q; // previous alarm, for the edge
	logic [1:0] din_lvl; // filtered input levels
	logic [1:0] din_chg; // filtered input change pulses
	logic [9:0] ain1_pct; // scaled first input
	logic [9:0] ain2_pct; // scaled second input
	logic [RW+9:0] retx_prod; // span times value
	logic [9:0] retx_val; // chosen quantity
	logic [3:0] irq_set; // this cycle's events
	logic aux_prev_q; // aux level one cycle back, for the loss event
	logic acc; // request pending first cycle
	logic wr_go; // write takes effect
	pwc_pkg::pwc_din_fn_t fn1; // first input function
	pwc_pkg::pwc_din_fn_t fn2; // second input function
	pwc_pkg::pwc_ain2_fn_t a2fn; // use of second analog input
	pwc_pkg::pwc_ctrl_t ctrl_d; // resolved controls

	assign fn1 = pwc_pkg::pwc_din_fn_t'(cfg_q[`PWC_CFG_DIN1_FN +: 3]);
	assign fn2 = pwc_pkg::pwc_din_fn_t'(cfg_q[`PWC_CFG_DIN2_FN +: 3]);
	assign a2fn = pwc_pkg::pwc_ain2_fn_t'(cfg_q[`PWC_CFG_AIN2_FN +: 2]);

	// ****************************************
	// input conditioning
	// ****************************************
	// one debouncer per isolated input
	for (genvar g = 0; g < 2; g++) begin : g_din
		pwc_din_filt #(.FILT_CYC(FILT_CYC)) u_filt (
			.mclk_i(mclk_i),
			.sys_rst_i(sys_rst_i),
			.pin_i(din_i[g]),
			.level_o(din_lvl[g]),
			.change_o(din_chg[g])
		);
	end

	// aux power sense comes from a pin
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aux_meta_q <= 1'b0;
			aux_q <= 1'b0;
		end else begin
			aux_meta_q <= aux_pwr_i;
			aux_q <= aux_meta_q;
		end
	end

	// analog readings to tenths of a percent
	pwc_scale #(.RW(RW)) u_ain1 (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.raw_i(ain1_raw_i),
		.lo_i(ain1_rng_q[RW-1:0]),
		.hi_i(ain1_rng_q[`PWC_RNG_HI +: RW]),
		.pct_o(ain1_pct)
	);
	pwc_scale #(.RW(RW)) u_ain2 (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.raw_i(ain2_raw_i),
		.lo_i(ain2_rng_q[RW-1:0]),
		.hi_i(ain2_rng_q[`PWC_RNG_HI +: RW]),
		.pct_o(ain2_pct)
	);

	// ****************************************
	// input function resolution
	// ****************************************
	// where both inputs carry one function the second decides
	function automatic logic fn_on(input pwc_pkg::pwc_din_fn_t f, input logic dflt);
		if (fn2 == f) begin
			fn_on = din_lvl[1];
		end else if (fn1 == f) begin
			fn_on = din_lvl[0];
		end else begin
			fn_on = dflt;
		end
	endfunction : fn_on

	function automatic logic fn_used(input pwc_pkg::pwc_din_fn_t f);
		fn_used = (fn1 == f) || (fn2 == f);
	endfunction : fn_used

	always_comb begin
		ctrl_d = '0;
		// run gating: absent function leaves output allowed
		ctrl_d.out_enable = fn_on(pwc_pkg::DF_ENABLE, 1'b1);
		// feedback override, else configured choice
		if (fn_on(pwc_pkg::DF_VOLT_FB, 1'b0)) begin
			ctrl_d.feedback = pwc_pkg::FB_VOLT;
		end else begin
			ctrl_d.feedback = pwc_pkg::pwc_fb_t'(cfg_q[`PWC_CFG_FB +: 3]);
		end
		// firing override, else configured method
		if (fn_on(pwc_pkg::DF_PHASE, 1'b0)) begin
			ctrl_d.firing = pwc_pkg::FI_PHASE;
		end else begin
			ctrl_d.firing = pwc_pkg::pwc_fire_t'(cfg_q[`PWC_CFG_FIRE +: 3]);
		end
		// set point source: input on means local
		if (fn_used(pwc_pkg::DF_LOC_REM)) begin
			ctrl_d.sp_remote = !fn_on(pwc_pkg::DF_LOC_REM, 1'b0);
		end else begin
			ctrl_d.sp_remote = panel_remote_q;
		end
		ctrl_d.remote_source_select = fn_on(pwc_pkg::DF_AIN_SEL, 1'b0);
		// logging and bakeout follow an assigned input, else stored bit
		ctrl_d.logging_en = fn_on(pwc_pkg::DF_LOGGING, cfg_q[`PWC_CFG_LOG]);
		ctrl_d.bakeout_en = fn_on(pwc_pkg::DF_BAKEOUT, cfg_q[`PWC_CFG_BAKE]);
	end

	// panel toggle, frozen while an input owns the source choice
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			panel_remote_q <= 1'b0;
		end else if (panel_lr_press_i && !fn_used(pwc_pkg::DF_LOC_REM)) begin
			panel_remote_q <= !panel_remote_q;
		end
	end

	// ****************************************
	// set point and analog routing
	// ****************************************
	// outputs registered so downstream loops see clean values
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_o <= '0;
			setpoint_o <= '0;
			ext_fb_o <= '0;
			cur_lim_sp_o <= '0;
		end else begin
			ctrl_o <= ctrl_d;
			// second input as alternate source only when so assigned
			if (!ctrl_d.sp_remote) begin
				setpoint_o <= sp_local_q;
			end else if (ctrl_d.remote_source_select && a2fn == pwc_pkg::A2_ALT_SP) begin
				setpoint_o <= ain2_pct;
			end else begin
				setpoint_o <= ain1_pct;
			end
			ext_fb_o <= (a2fn == pwc_pkg::A2_EXT_FB) ? ain2_pct : 10'h000;
			cur_lim_sp_o <= (a2fn == pwc_pkg::A2_CUR_LIM) ? ain2_pct : 10'h3E8;
		end
	end

	// ****************************************
	// alarm relay
	// ****************************************
	// heat sink always counts; others by selection mask
	always_comb begin
		alarm_d = alarm_i.heatsink_ot
			|| (cfg_q[`PWC_CFG_ALM_FN + 3] && alarm_i.heater_break)
			|| (cfg_q[`PWC_CFG_ALM_FN + 2] && alarm_i.shorted_sw)
			|| (cfg_q[`PWC_CFG_ALM_FN + 1] && alarm_i.cur_limit)
			|| (cfg_q[`PWC_CFG_ALM_FN + 0] && alarm_i.comm_wdog);
	end

	// fail safe: relay drops on alarm or lost aux power
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			relay_energize_o <= 1'b0;
			alarm_q <= 1'b0;
			hb_mon_en_o <= 1'b0;
			short_mon_en_o <= 1'b0;
		end else begin
			relay_energize_o <= aux_q && !alarm_d;
			alarm_q <= alarm_d;
			hb_mon_en_o <= cfg_q[`PWC_CFG_ALM_FN + 3];
			short_mon_en_o <= cfg_q[`PWC_CFG_ALM_FN + 2];
		end
	end

	// ****************************************
	// retransmit
	// ****************************************
	always_comb begin
		case (pwc_pkg::pwc_retx_t'(cfg_q[`PWC_CFG_RETX +: 2]))
			pwc_pkg::RT_SETPOINT: retx_val = setpoint_o;
			pwc_pkg::RT_CURRENT: retx_val = cur_pct_i;
			pwc_pkg::RT_VOLTAGE: retx_val = volt_pct_i;
			pwc_pkg::RT_POWER: retx_val = pwr_pct_i;
			default: retx_val = 10'h000;
		endcase
		// span must not be inverted; only a rising span is supported
		retx_prod = (RW+10)'(retx_rng_q[`PWC_RNG_HI +: RW] - retx_rng_q[RW-1:0])
			* (RW+10)'(retx_val);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			retx_o <= '0;
		end else begin
			retx_o <= retx_rng_q[RW-1:0]
				+ RW'(retx_prod / (RW+10)'(`PWC_PCT_FULL));
		end
	end

	// ****************************************
	// avalon-mm slave
	// ****************************************
	// one wait state: request seen, then answered the next edge
	assign acc = (avs_read_i || avs_write_i) && !ack_q;
	assign wr_go = avs_write_i && ack_q;
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
	assign avs_readdata_o = rdata_q;

	function automatic logic [31:0] merge(input logic [31:0] old);
		for (int i = 0; i < 4; i++) begin
			if (avs_byteenable_i[i]) begin
				old[8*i +: 8] = avs_writedata_i[8*i +: 8];
			end
		end
		merge = old;
	endfunction : merge

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc;
		end
	end

	// read mux captured in the wait cycle; unmapped reads zero
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= '0;
		end else if (acc && avs_read_i) begin
			case (avs_address_i)
				`PWC_OFS_CFG: rdata_q <= cfg_q;
				`PWC_OFS_AIN1_RNG: rdata_q <= ain1_rng_q;
				`PWC_OFS_AIN2_RNG: rdata_q <= ain2_rng_q;
				`PWC_OFS_RETX_RNG: rdata_q <= retx_rng_q;
				`PWC_OFS_STATUS: rdata_q <= {22'h0, relay_energize_o, alarm_q,
					aux_q, ctrl_o.out_enable, ctrl_o.sp_remote,
					ctrl_o.remote_source_select, ctrl_o.logging_en,
					ctrl_o.bakeout_en, din_lvl};
				`PWC_OFS_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
				`PWC_OFS_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
				`PWC_OFS_SP_LOCAL: rdata_q <= {22'h0, sp_local_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// configuration writes
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_q <= `PWC_RST_CFG;
			ain1_rng_q <= `PWC_RST_RNG;
			ain2_rng_q <= `PWC_RST_RNG;
			retx_rng_q <= `PWC_RST_RNG;
			sp_local_q <= `PWC_RST_SP;
			irq_mask_q <= `PWC_RST_MASK;
		end else if (wr_go) begin
			case (avs_address_i)
				`PWC_OFS_CFG: cfg_q <= merge(cfg_q);
				`PWC_OFS_AIN1_RNG: ain1_rng_q <= merge(ain1_rng_q);
				`PWC_OFS_AIN2_RNG: ain2_rng_q <= merge(ain2_rng_q);
				`PWC_OFS_RETX_RNG: retx_rng_q <= merge(retx_rng_q);
				`PWC_OFS_SP_LOCAL: sp_local_q <= 10'(merge({22'h0, sp_local_q}));
				`PWC_OFS_IRQ_MASK: irq_mask_q <= 4'(merge({28'h0, irq_mask_q}));
				default: ;
			endcase
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	// bits: 0 input one change, 1 input two change, 2 alarm rise, 3 aux lost
	// aux loss is taken from the synchronised level only, never the first stage
	assign irq_set = {aux_prev_q && !aux_q, alarm_d && !alarm_q, din_chg};

	// write-one-to-clear; a new event in the clear cycle wins
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_stat_q <= 4'h0;
		end else begin
			if (wr_go && avs_address_i == `PWC_OFS_IRQ_STAT && avs_byteenable_i[0]) begin
				irq_stat_q <= (irq_stat_q & ~avs_writedata_i[3:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
		end
	end

	// aux level delayed one cycle for the loss edge
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aux_prev_q <= 1'b0;
		end else begin
			aux_prev_q <= aux_q;
		end
	end
	assign irq_o = |(irq_stat_q & irq_mask_q);

	// ****************************************
	// checks
	// ****************************************
	property p_run_gate;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(fn2 == pwc_pkg::DF_ENABLE && !din_lvl[1]) |=> !ctrl_o.out_enable;
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("output on with gate low");

	property p_gate_second;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(fn1 == pwc_pkg::DF_ENABLE && fn2 == pwc_pkg::DF_ENABLE)
			|=> ctrl_o.out_enable == $past(din_lvl[1]);
	endproperty
	a_gate_second: assert property (p_gate_second) else $error("first gate obeyed");

	property p_volt_fb;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(fn_on(pwc_pkg::DF_VOLT_FB, 1'b0)) |=> ctrl_o.feedback == pwc_pkg::FB_VOLT;
	endproperty
	a_volt_fb: assert property (p_volt_fb) else $error("voltage feedback not forced");

	property p_phase;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(fn_on(pwc_pkg::DF_PHASE, 1'b0)) |=> ctrl_o.firing == pwc_pkg::FI_PHASE;
	endproperty
	a_phase: assert property (p_phase) else $error("phase firing not forced");

	property p_panel_locked;
		@(posedge mclk_i) disable iff (sys_rst_i)
		fn_used(pwc_pkg::DF_LOC_REM) |=> $stable(panel_remote_q);
	endproperty
	a_panel_locked: assert property (p_panel_locked) else $error("panel toggle acted");

	property p_relay_drop;
		@(posedge mclk_i) disable iff (sys_rst_i)
		alarm_d |=> !relay_energize_o;
	endproperty
	a_relay_drop: assert property (p_relay_drop) else $error("relay held on alarm");

	property p_relay_on;
		@(posedge mclk_i) disable iff (sys_rst_i)
		relay_energize_o |-> $past(aux_q) && !$past(alarm_d);
	endproperty
	a_relay_on: assert property (p_relay_on) else $error("relay on without cause");

	property p_heatsink;
		@(posedge mclk_i) disable iff (sys_rst_i)
		alarm_i.heatsink_ot |=> !relay_energize_o;
	endproperty
	a_heatsink: assert property (p_heatsink) else $error("heat sink alarm ignored");

	property p_logging;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(fn2 == pwc_pkg::DF_LOGGING) |=> ctrl_o.logging_en == $past(din_lvl[1]);
	endproperty
	a_logging: assert property (p_logging) else $error("logging not following input");

	property p_bakeout;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(fn1 == pwc_pkg::DF_BAKEOUT && fn2 != pwc_pkg::DF_BAKEOUT)
			|=> ctrl_o.bakeout_en == $past(din_lvl[0]);
	endproperty
	a_bakeout: assert property (p_bakeout) else $error("bakeout not following input");
endmodule : pwc_io_ctrl
`default_nettype wire

// ---- tb/pwc_panel_model.sv ----
// Purpose: panel switch model driving the two isolated digital inputs
// Assumes: contacts bounce once whenever they change
// Notes: bounce lasts one clock, far shorter than the filter span
`timescale 1ns/10ps
`default_nettype none
module pwc_panel_model (
	input wire logic mclk_i,
	input wire logic [1:0] want_i,
	output logic [1:0] din_o
);
	logic [1:0] last_q; // last settled contact level
	logic bounce_q; // in the bounce cycle
	// ****************************************
	// change, fall back once, then settle
	// ****************************************
	initial begin
		din_o = 2'h0;
		last_q = 2'h0;
		bounce_q = 1'b0;
	end
	always @(posedge mclk_i) begin
		if (want_i != last_q && !bounce_q) begin
			din_o <= want_i;
			bounce_q <= 1'b1;
		end else if (bounce_q) begin
			din_o <= last_q; // glitch the filter must hide
			last_q <= want_i;
			bounce_q <= 1'b0;
		end else begin
			din_o <= want_i;
		end
	end
endmodule : pwc_panel_model
`default_nettype wire

// ---- tb/pwc_io_ctrl_bench.sv ----
// Purpose: self-checking bench of the input function and relay block
// Assumes: short filter span of 4 cycles
// Notes: requests move and waits are sampled on rising edges
`timescale 1ns/10ps
`default_nettype none
`include "pwc_defs.svh"
module pwc_io_ctrl_bench;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0, aux_pwr_i = 1'b1;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
	logic avs_waitrequest_o, relay_energize_o, irq_o, hb_mon_en_o;
	logic [1:0] din_i, want = 2'h0;
	logic [11:0] ain1_raw_i = 12'h800, ain2_raw_i = 12'h400, retx_o;
	logic [9:0] setpoint_o, ext_fb_o, cur_lim_sp_o;
	logic panel_lr_press_i = 1'b0, short_mon_en_o;
	pwc_pkg::pwc_alarm_t alarm_i = '0;
	pwc_pkg::pwc_ctrl_t ctrl_o;
	int n_fail = 0, samples_checked = 0;
	// ****************************************
	// clock, partner and device
	// ****************************************
	initial forever #4 mclk_i = ~mclk_i;
	pwc_panel_model u_pan (.mclk_i(mclk_i), .want_i(want), .din_o(din_i));
	pwc_io_ctrl #(.FILT_CYC(4), .RW(12)) u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.din_i(din_i), .aux_pwr_i(aux_pwr_i), .panel_lr_press_i(panel_lr_press_i),
		.ain1_raw_i(ain1_raw_i), .ain2_raw_i(ain2_raw_i), .cur_pct_i(10'h000),
		.volt_pct_i(10'h000), .pwr_pct_i(10'h000), .alarm_i(alarm_i), .ctrl_o(ctrl_o),
		.setpoint_o(setpoint_o), .ext_fb_o(ext_fb_o), .cur_lim_sp_o(cur_lim_sp_o),
		.hb_mon_en_o(hb_mon_en_o), .short_mon_en_o(short_mon_en_o),
		.relay_energize_o(relay_energize_o), .retx_o(retx_o), .irq_o(irq_o));
	// ****************************************
	// bus, pin, compare and closing tasks
	// ****************************************
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o; // taken at the completing edge
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		repeat (2) @(posedge mclk_i); // registered results settle before checks
	endtask : acc
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic pins(input logic [1:0] p);
		want <= p;
		repeat (24) @(posedge mclk_i); // bounce, sync, filter, register
	endtask : pins
	task automatic test_done;
		if (n_fail == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	// ****************************************
	// watchdog: whole run is a few hundred cycles
	// ****************************************
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_fail++;
		test_done();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		acc(1'b0, `PWC_OFS_AIN1_RNG, 32'h0);
		chk("ain1 range", `PWC_RST_RNG, rd);
		acc(1'b0, `PWC_OFS_CFG, 32'h0);
		chk("cfg", `PWC_RST_CFG, rd);
		panel_lr_press_i <= 1'b1; // toggle allowed: no source input yet
		@(posedge mclk_i);
		panel_lr_press_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk("relay idle", 32'h1, 32'(relay_energize_o));
		chk("panel toggle", 32'h1, 32'(ctrl_o.sp_remote));
		acc(1'b1, `PWC_OFS_CFG, 32'h0000_0011); // both inputs gate the run
		pins(2'h1);
		chk("gate 2 off", 32'h0, 32'(ctrl_o.out_enable));
		pins(2'h2);
		chk("gate 2 on", 32'h1, 32'(ctrl_o.out_enable));
		acc(1'b1, `PWC_OFS_CFG, 32'h0000_2442); // volt fb on 1, phase on 2
		pins(2'h3);
		chk("fb forced", 32'(pwc_pkg::FB_VOLT), 32'(ctrl_o.feedback));
		chk("fire forced", 32'(pwc_pkg::FI_PHASE), 32'(ctrl_o.firing));
		pins(2'h0);
		chk("fb stored", 32'(pwc_pkg::FB_CUR), 32'(ctrl_o.feedback));
		chk("fire stored", 32'(pwc_pkg::FI_BURST), 32'(ctrl_o.firing));
		acc(1'b1, `PWC_OFS_SP_LOCAL, 32'd200);
		acc(1'b1, `PWC_OFS_CFG, 32'h0000_0003); // source choice on input 1
		repeat (4) @(posedge mclk_i);
		chk("analog sp", 32'd500, 32'(setpoint_o));
		chk("retx sp", 32'h7FF, 32'(retx_o));
		acc(1'b1, `PWC_OFS_IRQ_MASK, 32'h1);
		acc(1'b1, `PWC_OFS_IRQ_STAT, 32'hF); // drop events of earlier steps
		chk("irq idle", 32'h0, 32'(irq_o));
		pins(2'h1);
		chk("local sp", 32'd200, 32'(setpoint_o));
		chk("irq set", 32'h1, 32'(irq_o));
		acc(1'b1, `PWC_OFS_IRQ_STAT, 32'h1);
		chk("irq clear", 32'h0, 32'(irq_o));
		acc(1'b1, `PWC_OFS_CFG, 32'h0000_0053); // source on 1, analog select on 2
		pins(2'h2);
		chk("ain2 sp", 32'd250, 32'(setpoint_o));
		chk("no ext fb", 32'h0, 32'(ext_fb_o));
		chk("full limit", 32'd1000, 32'(cur_lim_sp_o));
		panel_lr_press_i <= 1'b1; // must be ignored: an input owns the source
		@(posedge mclk_i);
		panel_lr_press_i <= 1'b0;
		acc(1'b1, `PWC_OFS_CFG, 32'h0010_0053); // second analog as feedback
		chk("ext fb", 32'd250, 32'(ext_fb_o));
		chk("ain1 sp", 32'd500, 32'(setpoint_o));
		acc(1'b1, `PWC_OFS_CFG, 32'h0020_0053); // second analog as limit
		chk("limit sp", 32'd250, 32'(cur_lim_sp_o));
		acc(1'b1, `PWC_OFS_CFG, 32'h0);
		alarm_i <= 5'h10; // heater break, not selected
		repeat (4) @(posedge mclk_i);
		chk("unselected", 32'h1, 32'(relay_energize_o));
		chk("panel held", 32'h1, 32'(ctrl_o.sp_remote));
		acc(1'b1, `PWC_OFS_CFG, 32'h0C00_0000);
		chk("hb monitor", 32'h1, 32'(hb_mon_en_o));
		chk("short monitor", 32'h1, 32'(short_mon_en_o));
		chk("hb trip", 32'h0, 32'(relay_energize_o));
		alarm_i <= 5'h01;
		acc(1'b1, `PWC_OFS_CFG, 32'h0);
		chk("heat sink", 32'h0, 32'(relay_energize_o));
		chk("hb monitor off", 32'h0, 32'(hb_mon_en_o));
		alarm_i <= 5'h00;
		aux_pwr_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		chk("no aux", 32'h0, 32'(relay_energize_o));
		test_done();
	end
endmodule : pwc_io_ctrl_bench
`default_nettype wire
